//--- logic/gcoc_top.v
// general configuration registers and the output control behind them
//
// Behaviour
// - without override, internal output enable is 1, stored drive bit ignored.
// - without override, idle state choice is 1, stored choice bit ignored.
// - with override set, drive and idle choice come from register bits.
// - oscillator out bit and no link: oscillator clock on pixel clock output.
// - idle state choice with drive value sets outputs while link is down.
// - return link CRC generated only while its enable is 1; resets to 1.
// - pull direction bit: 1 pull-down, 0 pull-up on undriven inputs; resets 1.
// - filter enable rejects pulses under two pixel clocks on valid and syncs.
// - line sync filter is 2 clocks single lane, 4 clocks dual lane.
// - remote forward bit passes I2C through when target address matches.
// - write auto-acknowledge acks I2C writes regardless of link acquisition.
// - pixel gating bit matters only with non protected serializer; a protected one always gates by valid.
// - logic reset clears datapath but keeps registers, then clears itself.
`timescale 1ns/1ps
`default_nettype none
`include "gcoc_defines.vh"

module gcoc_top (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  // register port
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // link state
  input wire link_acquired_in,
  input wire dual_lane_in,
  input wire serializer_protected_in,
  input wire [1:0] osc_freq_sel_in,
  // pixel input side
  input wire pclk_in,
  input wire pix_tick_in,
  input wire data_valid_strobe_in,
  input wire line_sync_in,
  input wire frame_sync_in,
  input wire [23:0] pixel_in,
  // pixel output side
  output reg pclk_out,
  output reg data_valid_strobe_out,
  output reg line_sync_out,
  output reg frame_sync_out,
  output reg [23:0] pixel_out,
  output reg pixel_oe_out,
  // i2c and misc control
  input wire i2c_addr_match_in,
  output reg i2c_forward_out,
  output reg i2c_write_ack_ok_out,
  output reg return_link_crc_gen_on_out,
  output reg undriven_input_pull_dir_out,
  output reg logic_reset_keep_regs_out
);

  reg [7:0] general_config_a_r;
  reg [7:0] general_config_b_r;
  reg logic_rst_r;
  reg [7:0] osc_cnt_r;
  reg osc_clk_r;
  wire wr_a;
  wire wr_b;
  wire wr_rst;
  wire override;
  wire out_drive;
  wire idle_state_choice;
  wire filter_en;
  wire gate_on;
  wire [2:0] line_depth;
  wire [7:0] osc_half;
  wire dv_filt;
  wire ls_filt;
  wire fs_filt;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // oscillator half period minus one, in system clocks, per frequency setting
  function [7:0] gcoc_osc_half;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: gcoc_osc_half = `GCOC_OSC_HALF_0;
        2'h1: gcoc_osc_half = `GCOC_OSC_HALF_1;
        2'h2: gcoc_osc_half = `GCOC_OSC_HALF_2;
        default: gcoc_osc_half = `GCOC_OSC_HALF_3;
      endcase
    end
  endfunction

  // ------------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------------
  assign wr_a = reg_wr_in && (reg_addr_in == `GCOC_ADDR_CFG_A);
  assign wr_b = reg_wr_in && (reg_addr_in == `GCOC_ADDR_CFG_B);
  assign wr_rst = reg_wr_in && (reg_addr_in == `GCOC_ADDR_RESET);

  // config registers; only the system reset touches them, not logic reset
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      general_config_a_r <= `GCOC_CFG_A_RST;
      general_config_b_r <= `GCOC_CFG_B_RST;
    end else begin
      if (wr_a) begin
        general_config_a_r <= reg_wdata_in & `GCOC_CFG_A_MASK;
      end
      if (wr_b) begin
        general_config_b_r <= reg_wdata_in & `GCOC_CFG_B_MASK;
      end
    end
  end

  // one-cycle logic reset pulse; the bit never stores, so it self-clears
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      logic_rst_r <= 1'b0;
      logic_reset_keep_regs_out <= 1'b0;
    end else begin
      logic_rst_r <= wr_rst && reg_wdata_in[`GCOC_RESET_KEEP_REGS];
      logic_reset_keep_regs_out <= wr_rst && reg_wdata_in[`GCOC_RESET_KEEP_REGS];
    end
  end

  // read data, registered one cycle after the strobe
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `GCOC_ADDR_CFG_A: reg_rdata_out <= general_config_a_r & `GCOC_CFG_A_MASK;
        `GCOC_ADDR_CFG_B: reg_rdata_out <= general_config_b_r & `GCOC_CFG_B_MASK;
        default: reg_rdata_out <= 8'h00; // reset bit reads back zero
      endcase
    end
  end

  // ------------------------------------------------------------------
  // output control decode
  // ------------------------------------------------------------------
  assign override = general_config_a_r[`GCOC_A_OVERRIDE];
  assign out_drive = override ? general_config_a_r[`GCOC_A_OUT_DRIVE] : 1'b1;
  assign idle_state_choice = override ? general_config_a_r[`GCOC_A_IDLE_STATE] : 1'b1;
  assign filter_en = general_config_b_r[`GCOC_B_FILTER_EN];
  // a protected serializer always gates; the bit only matters otherwise
  assign gate_on = serializer_protected_in || general_config_b_r[`GCOC_B_PIX_GATE];
  assign line_depth = dual_lane_in ? `GCOC_FILT_LONG : `GCOC_FILT_SHORT;
  assign osc_half = gcoc_osc_half(osc_freq_sel_in);

  // ------------------------------------------------------------------
  // sync and valid filters
  // ------------------------------------------------------------------
  gcoc_sync_filter u_dv_filt (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .logic_rst_in(logic_rst_r),
    .enable_in(filter_en),
    .pix_tick_in(pix_tick_in),
    .depth_in(`GCOC_FILT_SHORT),
    .level_in(data_valid_strobe_in),
    .level_out(dv_filt)
  );

  gcoc_sync_filter u_ls_filt (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .logic_rst_in(logic_rst_r),
    .enable_in(filter_en),
    .pix_tick_in(pix_tick_in),
    .depth_in(line_depth),
    .level_in(line_sync_in),
    .level_out(ls_filt)
  );

  gcoc_sync_filter u_fs_filt (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .logic_rst_in(logic_rst_r),
    .enable_in(filter_en),
    .pix_tick_in(pix_tick_in),
    .depth_in(`GCOC_FILT_SHORT),
    .level_in(frame_sync_in),
    .level_out(fs_filt)
  );

  // ------------------------------------------------------------------
  // internal oscillator
  // ------------------------------------------------------------------
  // divided square wave; runs only while it may be shown, to save power
  always @(posedge mclk_in) begin
    if (!rst_b_in || logic_rst_r) begin
      osc_cnt_r <= 8'h00;
      osc_clk_r <= 1'b0;
    end else if (general_config_a_r[`GCOC_A_NO_LINK_OSC] && !link_acquired_in) begin
      if (osc_cnt_r >= osc_half) begin
        osc_cnt_r <= 8'h00;
        osc_clk_r <= ~osc_clk_r;
      end else begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
      end
    end else begin
      osc_cnt_r <= 8'h00;
      osc_clk_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // pixel output stage
  // ------------------------------------------------------------------
  // link down: idle choice 1 drives low only while drive is set, 0 releases pins
  always @(posedge mclk_in) begin
    if (!rst_b_in || logic_rst_r) begin
      pclk_out <= 1'b0;
      data_valid_strobe_out <= 1'b0;
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      pixel_out <= 24'h000000;
      pixel_oe_out <= 1'b0;
    end else if (link_acquired_in) begin
      pclk_out <= pclk_in;
      data_valid_strobe_out <= dv_filt;
      line_sync_out <= ls_filt;
      frame_sync_out <= fs_filt;
      pixel_out <= (gate_on && !dv_filt) ? 24'h000000 : pixel_in;
      pixel_oe_out <= out_drive;
    end else begin
      pclk_out <= general_config_a_r[`GCOC_A_NO_LINK_OSC] ? osc_clk_r : 1'b0;
      data_valid_strobe_out <= 1'b0;
      line_sync_out <= 1'b0;
      frame_sync_out <= 1'b0;
      pixel_out <= 24'h000000;
      pixel_oe_out <= out_drive && idle_state_choice;
    end
  end

  // ------------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------------
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      i2c_forward_out <= 1'b0;
      i2c_write_ack_ok_out <= 1'b0;
      return_link_crc_gen_on_out <= 1'b1;
      undriven_input_pull_dir_out <= 1'b1;
    end else begin
      i2c_forward_out <= general_config_b_r[`GCOC_B_REMOTE_FWD] && i2c_addr_match_in;
      i2c_write_ack_ok_out <= general_config_b_r[`GCOC_B_AUTO_ACK] || link_acquired_in;
      return_link_crc_gen_on_out <= general_config_b_r[`GCOC_B_CRC_GEN];
      undriven_input_pull_dir_out <= general_config_b_r[`GCOC_B_PULL_DIR];
    end
  end

endmodule

`default_nettype wire

//--- logic/gcoc_defines.vh
// constants for the general configuration and output control block
`ifndef GCOC_DEFINES_VH
`define GCOC_DEFINES_VH

// --------------------------------------------------------------------
// register offsets
// --------------------------------------------------------------------
`define GCOC_ADDR_RESET 8'h01
`define GCOC_ADDR_CFG_A 8'h02
`define GCOC_ADDR_CFG_B 8'h03

// --------------------------------------------------------------------
// reset values and writable masks
// --------------------------------------------------------------------
`define GCOC_CFG_A_RST 8'h00
`define GCOC_CFG_B_RST 8'h70
`define GCOC_CFG_A_MASK 8'hF0
`define GCOC_CFG_B_MASK 8'h7E

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define GCOC_A_OUT_DRIVE 7
`define GCOC_A_OVERRIDE 6
`define GCOC_A_NO_LINK_OSC 5
`define GCOC_A_IDLE_STATE 4
`define GCOC_B_CRC_GEN 6
`define GCOC_B_PULL_DIR 5
`define GCOC_B_FILTER_EN 4
`define GCOC_B_REMOTE_FWD 3
`define GCOC_B_AUTO_ACK 2
`define GCOC_B_PIX_GATE 1
`define GCOC_RESET_KEEP_REGS 0

// --------------------------------------------------------------------
// timing counts
// --------------------------------------------------------------------
`define GCOC_FILT_SHORT 3'h2
`define GCOC_FILT_LONG 3'h4
`define GCOC_OSC_HALF_0 8'h01
`define GCOC_OSC_HALF_1 8'h03
`define GCOC_OSC_HALF_2 8'h07
`define GCOC_OSC_HALF_3 8'h0F

`endif

//--- logic/gcoc_sync_filter.v
// glitch filter for one sync or valid strobe
`timescale 1ns/1ps
`default_nettype none

module gcoc_sync_filter (
  // clock and reset
  input wire mclk_in,
  input wire rst_b_in,
  input wire logic_rst_in,
  // control
  input wire enable_in,
  input wire pix_tick_in,
  input wire [2:0] depth_in,
  // data
  input wire level_in,
  output reg level_out
);

  reg [2:0] stable_cnt_r;

  // ------------------------------------------------------------------
  // filter
  // ------------------------------------------------------------------
  // a change is passed only once it has held for depth pixel clocks
  always @(posedge mclk_in) begin
    if (!rst_b_in || logic_rst_in) begin
      stable_cnt_r <= 3'h0;
      level_out <= 1'b0;
    end else if (!enable_in) begin
      stable_cnt_r <= 3'h0;
      level_out <= level_in;
    end else if (level_in == level_out) begin
      stable_cnt_r <= 3'h0; // short pulse dropped, count restarts
    end else if (pix_tick_in) begin
      if (stable_cnt_r + 3'h1 >= depth_in) begin
        level_out <= level_in;
        stable_cnt_r <= 3'h0;
      end else begin
        stable_cnt_r <= stable_cnt_r + 3'h1;
      end
    end
  end

endmodule

`default_nettype wire

//--- test/gcoc_chk_sva.sv
// assertions on the register port and control outputs of gcoc_top
`timescale 1ns/1ps
`default_nettype none
module gcoc_chk (
  // clock, reset and register port
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // control outputs
  input wire logic i2c_forward_out,
  input wire logic i2c_write_ack_ok_out,
  input wire logic return_link_crc_gen_on_out,
  input wire logic undriven_input_pull_dir_out,
  input wire logic logic_reset_keep_regs_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // write to the second config register; outputs follow two edges on
  wire wr_b = reg_wr_in && reg_addr_in == 8'h03;
  a_crc_set: assert property (wr_b && reg_wdata_in[6] |-> ##2 return_link_crc_gen_on_out)
    else $error("crc enable did not follow write");
  a_pull_clear: assert property (wr_b && !reg_wdata_in[5] |-> ##2 !undriven_input_pull_dir_out)
    else $error("pull direction did not follow write");
  a_fwd_off: assert property (wr_b && !reg_wdata_in[3] |-> ##2 !i2c_forward_out)
    else $error("forwarding while disabled");
  a_ack_on: assert property (wr_b && reg_wdata_in[2] |-> ##2 i2c_write_ack_ok_out)
    else $error("auto ack not granted");
  a_resv_b: assert property (reg_rd_in && reg_addr_in == 8'h03 |=>
    reg_rdata_out[7] == 1'b0 && reg_rdata_out[0] == 1'b0) else $error("reserved bit set");
  a_resv_a: assert property (reg_rd_in && reg_addr_in == 8'h02 |=>
    reg_rdata_out[3:0] == 4'h0) else $error("reserved nibble set");
  a_rst_vals: assert property ($rose(rst_b_in) |->
    return_link_crc_gen_on_out && undriven_input_pull_dir_out) else $error("bad reset value");
  // the pulse must be exactly one cycle wide, so it clears itself
  a_rst_pulse: assert property (reg_wr_in && reg_addr_in == 8'h01 && reg_wdata_in[0] |->
    ##1 logic_reset_keep_regs_out ##1 !logic_reset_keep_regs_out) else $error("bad pulse");
  c_wr_b: cover property (wr_b);
  c_lrst: cover property (logic_reset_keep_regs_out);
  c_rd_a: cover property (reg_rd_in && reg_addr_in == 8'h02);
endmodule
bind gcoc_top gcoc_chk gcoc_chk_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .i2c_forward_out(i2c_forward_out),
  .i2c_write_ack_ok_out(i2c_write_ack_ok_out),
  .return_link_crc_gen_on_out(return_link_crc_gen_on_out),
  .undriven_input_pull_dir_out(undriven_input_pull_dir_out),
  .logic_reset_keep_regs_out(logic_reset_keep_regs_out));
`default_nettype wire

//--- test/gcoc_tb_top.sv
// self-checking bench for the general configuration block
`timescale 1ns/1ps
`default_nettype none
module gcoc_tb_top;
  // ----------------
  // signals
  // ----------------
  logic mclk_in = 0, rst_b_in = 0, reg_wr = 0, reg_rd = 0, link = 0, dual = 0, prot = 0;
  logic pclk = 0, tick = 0, dv = 0, ls = 0, fs = 0, am = 0, seen, dr, ss;
  logic [7:0] addr = 0, wdata = 0, rdata, sa, sb, d, a, t;
  logic [1:0] fsel = 0;
  logic [23:0] pix = 0, pix_o;
  logic pclk_o, dv_o, ls_o, fs_o, oe, fwd, ack, crc, pull, lrst;
  logic [7:0] tbl [6] = '{8'hA2, 8'h82, 8'h97, 8'hD6, 8'hDD, 8'h23};
  int n_mismatch = 0, n_compared = 0, i, k;
  gcoc_top gcoc_top_i (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .link_acquired_in(link), .dual_lane_in(dual), .serializer_protected_in(prot),
    .osc_freq_sel_in(fsel), .pclk_in(pclk), .pix_tick_in(tick), .data_valid_strobe_in(dv),
    .line_sync_in(ls), .frame_sync_in(fs), .pixel_in(pix), .pclk_out(pclk_o),
    .data_valid_strobe_out(dv_o), .line_sync_out(ls_o), .frame_sync_out(fs_o),
    .pixel_out(pix_o), .pixel_oe_out(oe), .i2c_addr_match_in(am), .i2c_forward_out(fwd),
    .i2c_write_ack_ok_out(ack), .return_link_crc_gen_on_out(crc),
    .undriven_input_pull_dir_out(pull), .logic_reset_keep_regs_out(lrst));
  // ----------------
  // clock, tasks
  // ----------------
  initial begin
    forever #5 mclk_in = ~mclk_in;
  end
  // every step ends 1 ns after an edge, so drives never race the sample
  task cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // strobes drop for a cycle between accesses
  task wr(input logic [7:0] wa, input logic [7:0] wd);
    addr = wa;
    wdata = wd;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task rdc(input logic [7:0] ra, input logic [7:0] e, input string nm);
    addr = ra;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    chk(nm, rdata, e);
    cyc(1);
  endtask
  // count pclk_out toggles; any toggle means the oscillator is shown
  task osc(input logic [7:0] oa, input logic l, input logic e);
    int n;
    logic p;
    wr(8'h02, oa);
    sa = oa;
    link = l;
    pclk = 0;
    fsel = 2'($urandom);
    cyc(4);
    n = 0;
    p = pclk_o;
    repeat (40) begin
      cyc(1);
      n += int'(pclk_o !== p);
      p = pclk_o;
    end
    chk("osc_clock", 24'(n > 0), 24'(e));
  endtask
  task summarize;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ----------------
  // tests
  // ----------------
  initial begin
    d = 8'($urandom(49193));
    cyc(10);
    rst_b_in = 1;
    rdc(8'h02, 8'h00, "cfg_a_rst");
    rdc(8'h03, 8'h70, "cfg_b_rst");
    sa = 8'h00;
    sb = 8'h70;
    // random register traffic, first two writes all ones
    for (i = 0; i < 40; i++) begin
      k = (i < 2) ? i + 2 : $urandom % 4;
      d = (i < 2) ? 8'hFF : 8'($urandom);
      a = (k == 0) ? 8'h05 : 8'(k);
      {link, prot, am, dual, pclk, tick} = 6'($urandom);
      pix = 24'($urandom);
      wr(a, d);
      if (k == 2 && d[7] && !sa[7]) wr(8'h01, 8'h01);
      if (k == 2) sa = d & 8'hF0;
      if (k == 3) sb = d & 8'h7E;
      cyc(3);
      rdc(8'h02, sa, "cfg_a");
      rdc(8'h03, sb, "cfg_b");
      rdc(8'h05, 8'h00, "unmapped");
      rdc(8'h01, 8'h00, "reset_reg");
      dr = sa[6] ? sa[7] : 1'b1;
      ss = sa[6] ? sa[4] : 1'b1;
      chk("oe", oe, link ? dr : dr & ss);
      chk("crc", crc, sb[6]);
      chk("pull", pull, sb[5]);
      chk("fwd", fwd, sb[3] & am);
      chk("ack", ack, sb[2] | link);
      if (link || !sa[5]) chk("pclk", pclk_o, link & pclk);
      chk("pix", pix_o, (link && !(prot | sb[1])) ? pix : 24'h0);
    end
    osc(8'h20, 0, 1);
    osc(8'h00, 0, 0);
    osc(8'h20, 1, 0);
    // glitch filter table: enable, dual, signal, length, passes
    tick = 1;
    link = 1;
    for (i = 0; i < 6; i++) begin
      t = tbl[i];
      dual = t[6];
      sb = {3'b011, t[7], 4'h0};
      wr(8'h03, sb);
      cyc(4);
      seen = 0;
      for (k = 0; k < int'(t[3:1]) + 12; k++) begin
        dv = t[5:4] == 0 && k < int'(t[3:1]);
        ls = t[5:4] == 1 && k < int'(t[3:1]);
        fs = t[5:4] == 2 && k < int'(t[3:1]);
        cyc(1);
        seen |= (t[5:4] == 0) ? dv_o : (t[5:4] == 1) ? ls_o : fs_o;
      end
      chk("filter", seen, t[0]);
    end
    // gating: a plain serializer follows the bit, a protected one always gates
    prot = 0;
    pix = 24'($urandom);
    sb = 8'h02;
    wr(8'h03, sb);
    dv = 1;
    cyc(3);
    chk("gate_dv_hi", pix_o, pix);
    dv = 0;
    cyc(3);
    chk("gate_dv_lo", pix_o, 24'h0);
    prot = 1;
    sb = 8'h00;
    wr(8'h03, sb);
    cyc(2);
    chk("gate_prot", pix_o, 24'h0);
    dv = 1;
    cyc(3);
    chk("pass_prot", pix_o, pix);
    // logic reset clears the pixel path for a cycle but keeps the registers
    wr(8'h01, 8'h01);
    chk("lrst_pix", pix_o, 24'h0);
    dv = 0;
    cyc(2);
    rdc(8'h03, sb, "keep_cfg_b");
    // second reset in mid-run: registers and the crc and pull outputs back to defaults
    rst_b_in = 0;
    cyc(3);
    rst_b_in = 1;
    chk("crc_rst", crc, 1'b1);
    chk("pull_rst", pull, 1'b1);
    rdc(8'h02, 8'h00, "cfg_a_rst2");
    rdc(8'h03, 8'h70, "cfg_b_rst2");
    summarize;
  end
  // watchdog, far beyond the fewer than a thousand cycles the tests need
  initial begin
    #300000;
    n_mismatch++;
    summarize;
  end
endmodule
`default_nettype wire
